/* ebic_pkg.sv */
// Package for the external bus idle and chip-select extension block.
// Assumes a single 100 MHz bus clock and APB register access.
package ebic_pkg;
  localparam int unsigned EBIC_NUM_SPACES = 4;
  localparam logic [11:0] EBIC_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] EBIC_STATUS_OFFSET = 12'h004;
  localparam logic [15:0] EBIC_CTRL_RESET = 16'hFFFF;
  localparam int unsigned EBIC_IDLE_LSB = 8;
  localparam int unsigned EBIC_B2B_LSB = 4;
  localparam int unsigned EBIC_STRETCH_LSB = 0;
  localparam int unsigned EBIC_CTRL_WIDTH = 16;

  typedef enum logic [2:0] {
    EBIC_IDLE_ST = 3'b000,
    EBIC_PRE_ST = 3'b001,
    EBIC_STROBE_ST = 3'b011,
    EBIC_POST_ST = 3'b010,
    EBIC_GAP_ST = 3'b110
  } ebic_state_t;
endpackage : ebic_pkg

/* ebic_ctrl.sv */
// External bus cycle sequencer with idle insertion and select stretch.
// Assumes a requester on the same clock that holds its request until ack.
// How it works
// - CS2 idle count at bits 13:12, 0..3 cycles, resets to three.
// - CS1 idle count at bits 11:10, 0..3 cycles, resets to three.
// - CS0 idle count at bits 9:8, 0..3 cycles, resets to three.
// - Back-to-back same space with its bit set: select drops one cycle.
// - Write after read to the same space waits the larger of idle count and back-to-back.
// - CS3 back-to-back idle bit 7, set gives one cycle, resets set.
// - CS2 back-to-back idle bit 6, set gives one cycle, resets set.
// - CS1 back-to-back idle bit 5, set gives one cycle, resets set.
// - CS0 back-to-back idle bit 4, set gives one cycle, resets set.
// - Stretch adds one select cycle before and after; strobes stay inside.
// - CS3 stretch enable bit 3, resets enabled.
// - CS2 stretch enable bit 2, resets enabled.
// - CS1 stretch enable bit 1, resets enabled.
// - CS0 stretch enable bit 0, resets enabled.
// - Idle count applies after read to other space, or read then write.
// - Idle count comes from the previous access's space.
// - CS3 idle count at bits 15:14, same encoding, resets to three.
//
// Chosen here: the placing of the registers and the APB slave port.
module ebic_ctrl
  import ebic_pkg::*;
#(
  parameter int unsigned STROBE_CYCLES = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_req,
  input wire logic i_req_write,
  input wire logic [1:0] i_req_space,
  output logic o_ack,
  output logic [3:0] o_chip_select_n,
  output logic o_read_strobe_n,
  output logic o_write_strobes_n
);

  typedef struct packed {
    logic [15:0] ctrl;
    ebic_state_t state;
    logic [1:0] space;
    logic wr;
    logic have_prev;
    logic [1:0] prev_space;
    logic prev_wr;
    logic [2:0] cnt;
    logic [31:0] rdata;
  } ebic_regs_t;

  ebic_regs_t state_reg;
  ebic_regs_t state_next;

  logic [1:0] idle_cnt [EBIC_NUM_SPACES];
  logic b2b_idle [EBIC_NUM_SPACES];
  logic stretch [EBIC_NUM_SPACES];

  genvar g;
  generate
    for (g = 0; g < EBIC_NUM_SPACES; g++) begin : g_fields
      assign idle_cnt[g] = state_reg.ctrl[EBIC_IDLE_LSB + 2*g +: 2];
      assign b2b_idle[g] = state_reg.ctrl[EBIC_B2B_LSB + g];
      assign stretch[g] = state_reg.ctrl[EBIC_STRETCH_LSB + g];
    end
  endgenerate

  logic apb_acc;
  logic apb_wr;
  logic [2:0] gap;
  logic [2:0] gap_idle;
  logic [2:0] gap_b2b;
  logic same_space;
  logic after_read;
  logic [2:0] strobe_len;

  assign apb_acc = i_psel && i_penable;
  assign apb_wr = apb_acc && i_pwrite && (i_paddr == EBIC_CTRL_OFFSET);
  assign o_pready = 1'b1;
  assign o_pslverr = apb_acc && (i_paddr != EBIC_CTRL_OFFSET)
    && (i_paddr != EBIC_STATUS_OFFSET);
  assign o_prdata = state_reg.rdata;
  assign strobe_len = 3'(STROBE_CYCLES);

  always_comb begin
    same_space = state_reg.have_prev && (state_reg.prev_space == i_req_space);
    after_read = state_reg.have_prev && !state_reg.prev_wr;
    // Idle count follows the space of the access just finished
    gap_idle = {1'b0, idle_cnt[state_reg.prev_space]};
    gap_b2b = {2'b00, b2b_idle[state_reg.prev_space]};
    gap = 3'b000;
    if (after_read && !same_space) begin
      gap = gap_idle;
    end else if (after_read && same_space && i_req_write) begin
      gap = (gap_idle > gap_b2b) ? gap_idle : gap_b2b;
    end else if (same_space) begin
      gap = gap_b2b;
    end
  end

  always_comb begin
    state_next = state_reg;
    o_ack = 1'b0;
    o_chip_select_n = 4'hF;
    o_read_strobe_n = 1'b1;
    o_write_strobes_n = 1'b1;
    if (apb_wr) begin
      state_next.ctrl = i_pwdata[EBIC_CTRL_WIDTH-1:0];
    end
    // Captured in the setup cycle so it stands at the zero-wait access edge
    if (i_psel && !i_penable && !i_pwrite) begin
      state_next.rdata = 32'h0000_0000;
      if (i_paddr == EBIC_CTRL_OFFSET) begin
        state_next.rdata = {16'h0000, state_reg.ctrl};
      end else if (i_paddr == EBIC_STATUS_OFFSET) begin
        state_next.rdata = {24'h000000, state_reg.prev_wr,
          state_reg.prev_space, state_reg.have_prev, 1'b0, state_reg.state};
      end
    end
    unique case (state_reg.state)
      EBIC_IDLE_ST: begin
        if (i_req) begin
          state_next.space = i_req_space;
          state_next.wr = i_req_write;
          if (gap != 3'b000) begin
            state_next.cnt = gap - 3'b001;
            state_next.state = EBIC_GAP_ST;
          end else if (stretch[i_req_space]) begin
            state_next.state = EBIC_PRE_ST;
          end else begin
            state_next.cnt = strobe_len - 3'b001;
            state_next.state = EBIC_STROBE_ST;
          end
        end
      end
      EBIC_GAP_ST: begin
        // Selects high here separate consecutive cycles
        if (state_reg.cnt != 3'b000) begin
          state_next.cnt = state_reg.cnt - 3'b001;
        end else if (stretch[state_reg.space]) begin
          state_next.state = EBIC_PRE_ST;
        end else begin
          state_next.cnt = strobe_len - 3'b001;
          state_next.state = EBIC_STROBE_ST;
        end
      end
      EBIC_PRE_ST: begin
        o_chip_select_n[state_reg.space] = 1'b0;
        state_next.cnt = strobe_len - 3'b001;
        state_next.state = EBIC_STROBE_ST;
      end
      EBIC_STROBE_ST: begin
        o_chip_select_n[state_reg.space] = 1'b0;
        o_read_strobe_n = state_reg.wr;
        o_write_strobes_n = !state_reg.wr;
        if (state_reg.cnt != 3'b000) begin
          state_next.cnt = state_reg.cnt - 3'b001;
        end else begin
          state_next.have_prev = 1'b1;
          state_next.prev_space = state_reg.space;
          state_next.prev_wr = state_reg.wr;
          if (stretch[state_reg.space]) begin
            state_next.state = EBIC_POST_ST;
          end else begin
            o_ack = 1'b1;
            state_next.state = EBIC_IDLE_ST;
          end
        end
      end
      EBIC_POST_ST: begin
        // Strobes already released; select held one more cycle
        o_chip_select_n[state_reg.space] = 1'b0;
        o_ack = 1'b1;
        state_next.state = EBIC_IDLE_ST;
      end
      default: begin
        state_next.state = EBIC_IDLE_ST;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg.ctrl <= EBIC_CTRL_RESET;
      state_reg.state <= EBIC_IDLE_ST;
      state_reg.space <= 2'b00;
      state_reg.wr <= 1'b0;
      state_reg.have_prev <= 1'b0;
      state_reg.prev_space <= 2'b00;
      state_reg.prev_wr <= 1'b0;
      state_reg.cnt <= 3'b000;
      state_reg.rdata <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : ebic_ctrl

/* ebic_mem_model.sv */
// Memory and I/O device model on the external bus.
// Assumes active-low selects and strobes; counts finished strobe pulses.
module ebic_mem_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobes_n,
  output logic [31:0] o_cycle_count
);
  logic strb_reg;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cycle_count <= '0;
      strb_reg <= 1'b0;
    end else begin
      strb_reg <= !i_read_strobe_n || !i_write_strobes_n;
      if (strb_reg && i_read_strobe_n && i_write_strobes_n)
        o_cycle_count <= o_cycle_count + 32'h1;
    end
  end
endmodule : ebic_mem_model

/* ebic_ctrl_checker.sv */
// Port-level checks on the bus sequencer, bound to ebic_ctrl.
// Assumes one bus clock and the active-low async reset.
module ebic_ctrl_checker (
  input wire logic i_clk, i_rst_n, i_req, o_ack,
  input wire logic o_read_strobe_n, o_write_strobes_n,
  input wire logic [3:0] o_chip_select_n
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic strb = !o_read_strobe_n || !o_write_strobes_n;
  wire logic idle = &o_chip_select_n;
  property p_one; $onehot0(~o_chip_select_n); endproperty
  property p_in; strb |-> !idle; endproperty
  property p_excl; !(!o_read_strobe_n && !o_write_strobes_n); endproperty
  property p_ack; o_ack |-> !idle; endproperty
  property p_sep; o_ack |=> idle && !strb; endproperty
  property p_pulse; o_ack |=> !o_ack; endproperty
  property p_wait; $rose(i_req) |-> ##[1:12] o_ack; endproperty
  property p_rst; $rose(i_rst_n) |-> idle && !o_ack; endproperty
  a_one: assert property (p_one) else $error("two selects low");
  a_in: assert property (p_in) else $error("strobe outside select");
  a_excl: assert property (p_excl) else $error("both strobes low");
  a_ack: assert property (p_ack) else $error("ack without select");
  a_sep: assert property (p_sep) else $error("no idle after access");
  a_pulse: assert property (p_pulse) else $error("ack too long");
  a_wait: assert property (p_wait) else $error("access never ends");
  a_rst: assert property (p_rst) else $error("bus busy at reset");
  c_wr: cover property (o_ack && !o_write_strobes_n);
  c_chain: cover property (o_ack && i_req);
  c_rd: cover property ($fell(o_read_strobe_n));
endmodule : ebic_ctrl_checker
bind ebic_ctrl ebic_ctrl_checker chk_u (.i_clk, .i_rst_n, .i_req, .o_ack,
  .o_read_strobe_n, .o_write_strobes_n, .o_chip_select_n);

/* external_bus_idle_and_cs_extension_test.sv */
// Self-checking bench: APB setup, then chained bus accesses.
// Assumes the sequencer takes a held request as the next access.
module external_bus_idle_and_cs_extension_test import ebic_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_rst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic i_req = 0, i_req_write = 0, o_pready, o_pslverr, o_ack, err, pv = 0;
  logic o_read_strobe_n, o_write_strobes_n, pw;
  logic [1:0] i_req_space = '0, ps;
  logic [3:0] o_chip_select_n;
  logic [11:0] i_paddr = '0;
  logic [15:0] ctrl = 16'hFFFF;
  logic [31:0] i_pwdata = '0, o_prdata, rd, cnt;
  int fail_count = 0, tests_run = 0, seed = 32'hA970, n, nacc = 0;
  ebic_ctrl dut_u (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_req,
    .i_req_write, .i_req_space, .o_ack, .o_chip_select_n,
    .o_read_strobe_n, .o_write_strobes_n);
  ebic_mem_model mem_u (.i_clk, .i_rst_n, .i_read_strobe_n(o_read_strobe_n),
    .i_write_strobes_n(o_write_strobes_n), .o_cycle_count(cnt));
  initial forever #5 i_clk = ~i_clk;
  task automatic give_verdict();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic chk(string nm, logic [31:0] e, logic [31:0] got);
    tests_run++;
    if (got !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, e, got);
    end
  endtask : chk
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    i_psel <= 1'b1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
    @(posedge i_clk) i_penable <= 1'b1;
    n = 0;
    do begin @(posedge i_clk); n++; end while (o_pready !== 1'b1 && n < 20);
    if (o_pready !== 1'b1) begin fail_count++; give_verdict(); end
    err = o_pslverr;
    rd = o_prdata;
    i_psel <= 1'b0; i_penable <= 1'b0;
    // One idle cycle, so the next setup never reassigns psel in this step
    @(posedge i_clk);
  endtask : apb
  task automatic setc(logic [15:0] v);
    ctrl = v;
    apb(1'b1, 12'h000, {16'h0000, v});
    apb(1'b0, 12'h000, 32'h0); chk("ctrl", {16'h0000, v}, rd);
  endtask : setc
  function automatic int gap(logic [1:0] s, logic w);
    int iw, cw;
    iw = ctrl[8 + 2 * ps +: 2];
    cw = ctrl[4 + ps];
    if (!pv) return 0;
    if (!pw && ps != s) return iw;
    if (!pw && w) return iw > cw ? iw : cw;
    return ps == s ? cw : 0;
  endfunction : gap
  task automatic acc(logic [1:0] s, logic w);
    int e;
    e = gap(s, w) + ctrl[s] + 2;
    i_req <= 1'b1; i_req_space <= s; i_req_write <= w;
    for (n = 1; n < 16; n++) begin
      @(negedge i_clk);
      if (!(w ? o_write_strobes_n : o_read_strobe_n)) break;
    end
    chk("strobe delay", e, n);
    n = 0;
    while (o_ack !== 1'b1 && n < 16) begin @(negedge i_clk); n++; end
    if (o_ack !== 1'b1) begin fail_count++; give_verdict(); end
    @(posedge i_clk);
    pv = 1'b1; ps = s; pw = w; nacc++;
  endtask : acc
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    apb(1'b0, 12'h000, 32'h0); chk("ctrl reset", 32'h0000FFFF, rd);
    apb(1'b0, 12'h008, 32'h0); chk("slverr", 32'h1, err);
    repeat (6) begin
      for (int k = 0; k < 6; k++) acc(2'($random(seed)), 1'($random(seed)));
      i_req <= 1'b0;
      setc(16'($random(seed)));
    end
    setc(16'hC000);
    acc(2'h3, 1'b0); acc(2'h2, 1'b0); acc(2'h2, 1'b1); acc(2'h3, 1'b1);
    i_req <= 1'b0;
    repeat (4) @(posedge i_clk);
    chk("model count", nacc, cnt);
    give_verdict();
  end
endmodule : external_bus_idle_and_cs_extension_test
